// File: src/fsr_pkg.sv
//----------------------------------------------------------------------
// Overview of operation
// - Byte 0 echoes the received command code
// - Byte 1 is 0x00 success, 0x01 unsupported
// - Byte 2 carries structure length on success
// - Bytes 3-63 hold sub-command data or zero
// - Byte 4 bit 7 enables CDC serial number
// - Clear bit means no serial number descriptor
// - Byte 4 bits 1-0 give security level
// - Byte 5 bits 4-0 divide clock output pin
// - Byte 6 bits 7-6 pick DAC reference level
// - Byte 6 bit 5 picks DAC reference source
// - Byte 6 bits 4-0 hold power-up DAC code
// - Byte 7 bit 6 arms falling-edge interrupt detect
// - Byte 7 bit 5 arms rising-edge interrupt detect
// - Byte 7 bits 4-3 pick ADC reference level
// - Byte 7 bit 2 reports reference source select
// - Bytes 8-9 return vendor identifier, low first
// - Unknown sub-code answers with unsupported status
//----------------------------------------------------------------------
package fsr_pkg;

  //--------------------------------------------------------------------
  // Command and status codes
  //--------------------------------------------------------------------
  localparam logic [7:0] CMD_READ_FLASH = 8'hB0;
  localparam logic [7:0] SUB_CHIP_SETTINGS = 8'h00;
  localparam logic [7:0] STAT_OK = 8'h00;
  localparam logic [7:0] STAT_UNSUP = 8'h01;

  //--------------------------------------------------------------------
  // Register byte addresses
  //--------------------------------------------------------------------
  localparam logic [7:0] ADR_CMD = 8'h00;
  localparam logic [7:0] ADR_CFG = 8'h04;
  localparam logic [7:0] ADR_VID = 8'h08;
  localparam logic [7:0] ADR_STATUS = 8'h0C;
  localparam logic [7:0] ADR_RESP = 8'h40;
  localparam int RESP_WORDS = 16;
  localparam int RESP_AW = 4;

  //--------------------------------------------------------------------
  // Settings word: bytes 4..7 of the chip-settings response
  //--------------------------------------------------------------------
  localparam int SN_EN_BIT = 7;
  localparam int SEC_LSB = 0;
  localparam int CLKDIV_LSB = 8;
  localparam int DAC_VAL_LSB = 16;
  localparam int DAC_SRC_BIT = 21;
  localparam int DAC_REF_LSB = 22;
  localparam int REF_SRC_BIT = 26;
  localparam int ADC_REF_LSB = 27;
  localparam int INT_POS_BIT = 29;
  localparam int INT_NEG_BIT = 30;
  // Implemented bits only; the rest never store
  localparam logic [31:0] CFG_MASK = 32'h7CFF_1F83;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [15:0] VID_RST = 16'h0000;

  //--------------------------------------------------------------------
  // Status register bits
  //--------------------------------------------------------------------
  localparam int ST_INT_BIT = 0;
  localparam int ST_CLKEN_BIT = 1;

endpackage : fsr_pkg

// File: src/fsr_clk_if.sv
`timescale 1ns/1ps
//----------------------------------------------------------------------
// Clock-output control between core and divider
//----------------------------------------------------------------------
interface fsr_clk_if;
  logic [4:0] div; // Half period in source clock cycles
  logic en; // Pin assigned to clock output
  logic lvl; // Divided clock level
  modport ctl (output div, output en, input lvl);
  modport gen (input div, input en, output lvl);
endinterface : fsr_clk_if

// File: src/fsr_clkout.sv
`timescale 1ns/1ps
//----------------------------------------------------------------------
// Clock output divider
//----------------------------------------------------------------------
module fsr_clkout (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Control from the core
  fsr_clk_if.gen clk
);

  logic [4:0] cnt_r; // Cycles spent in current half
  logic [4:0] cnt_nxt;
  logic lvl_r; // Output level flop
  logic lvl_nxt;
  logic [4:0] half; // Effective half period
  logic wrap; // End of half period

  // A zero divider would stall the pin, so it runs as one
  assign half = (clk.div == 5'h00) ? 5'h01 : clk.div;
  assign wrap = (cnt_r + 5'h01) >= half;
  assign cnt_nxt = (!clk.en || wrap) ? 5'h00 : cnt_r + 5'h01;
  // Pin parks low while not assigned to clock output
  assign lvl_nxt = !clk.en ? 1'b0 : (wrap ? ~lvl_r : lvl_r);
  assign clk.lvl = lvl_r;

  // Counter and level
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_r <= 5'h00;
      lvl_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      lvl_r <= lvl_nxt;
    end
  end

endmodule : fsr_clkout

// File: src/fsr_flash_resp.sv
`timescale 1ns/1ps
//----------------------------------------------------------------------
// Read-settings response builder with Wishbone register access
//----------------------------------------------------------------------
module fsr_flash_resp #(
  parameter logic [7:0] STRUCT_LEN = 8'h0A // Chip-settings length
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Wishbone slave
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  // Device pins and pin routing
  input wire logic intr_pin,
  input wire logic clkout_assign,
  output logic clkout,
  // Stored settings to the rest of the chip
  output logic serial_desc_en,
  output logic [1:0] sec_level,
  output logic [1:0] dac_vref_sel,
  output logic dac_src_internal_reference_module,
  output logic [4:0] dac_code,
  output logic [1:0] adc_vref_sel,
  output logic ref_src_vdd,
  output logic intr_flag
);

  //--------------------------------------------------------------------
  // State
  //--------------------------------------------------------------------
  logic ack_r; // Bus answer, one cycle
  logic [31:0] rdat_r; // Registered read data
  logic [15:0] cmd_r; // Last command: sub-code, code
  logic [31:0] cfg_r; // Stored settings bytes 4..7
  logic [15:0] vid_r; // usb_vendor_identifier
  logic intr_s1_r; // Synchroniser first stage
  logic intr_s2_r; // Synchroniser second stage
  logic intr_d_r; // Previous synchronised level
  logic intr_flag_r; // Sticky edge detection flag
  logic [31:0] resp_mem_r [fsr_pkg::RESP_WORDS]; // 64-byte report

  //--------------------------------------------------------------------
  // Bus decode
  //--------------------------------------------------------------------
  logic acc; // New request this cycle
  logic [7:0] badr; // Word-aligned byte address
  logic hit_cmd;
  logic hit_cfg;
  logic hit_vid;
  logic hit_st;
  logic hit_resp;
  logic wr_cmd; // Command write: builds the report
  logic wr_cfg;
  logic wr_vid;
  logic wr_st;
  logic [31:0] lane_m; // Byte-lane write mask
  logic [fsr_pkg::RESP_AW-1:0] ridx; // Response word index

  // Ack is held off for one cycle after each answer
  assign acc = wb_cyc && wb_stb && !ack_r;
  assign badr = {wb_adr[7:2], 2'b00};
  assign hit_cmd = badr == fsr_pkg::ADR_CMD;
  assign hit_cfg = badr == fsr_pkg::ADR_CFG;
  assign hit_vid = badr == fsr_pkg::ADR_VID;
  assign hit_st = badr == fsr_pkg::ADR_STATUS;
  assign hit_resp = badr[7:6] == fsr_pkg::ADR_RESP[7:6];
  assign ridx = badr[fsr_pkg::RESP_AW+1:2];
  // Command needs lane 0; sub-code is zero if lane 1 is off
  assign wr_cmd = acc && wb_we && hit_cmd && wb_sel[0];
  assign wr_cfg = acc && wb_we && hit_cfg;
  assign wr_vid = acc && wb_we && hit_vid;
  assign wr_st = acc && wb_we && hit_st && wb_sel[0];
  assign lane_m = {{8{wb_sel[3]}}, {8{wb_sel[2]}},
                   {8{wb_sel[1]}}, {8{wb_sel[0]}}};

  //--------------------------------------------------------------------
  // Report construction
  //--------------------------------------------------------------------
  logic [7:0] new_code; // Received command code
  logic [7:0] new_sub; // Received sub-code
  logic hit_ok; // Supported command and sub-code
  logic [7:0] stat_b; // Byte 1 value
  logic [7:0] len_b; // Byte 2 value

  assign new_code = wb_dat_w[7:0];
  assign new_sub = wb_sel[1] ? wb_dat_w[15:8] : 8'h00;
  // Only chip settings are served here; others are unsupported
  assign hit_ok = (new_code == fsr_pkg::CMD_READ_FLASH) &&
                  (new_sub == fsr_pkg::SUB_CHIP_SETTINGS);
  assign stat_b = hit_ok ? fsr_pkg::STAT_OK
                         : fsr_pkg::STAT_UNSUP;
  // Length is meaningful only on success; zero otherwise
  assign len_b = hit_ok ? STRUCT_LEN : 8'h00;

  // One report word from the settings snapshot
  function automatic logic [31:0] resp_word(
    input int idx,
    input logic ok,
    input logic [31:0] w0,
    input logic [31:0] cfg,
    input logic [15:0] usb_vendor_identifier
  );
    logic [31:0] w;
    w = 32'h0000_0000; // Byte 3 and all unused bytes read zero
    if (idx == 0)
      w = w0;
    else if (idx == 1 && ok)
      w = cfg & fsr_pkg::CFG_MASK;
    else if (idx == 2 && ok)
      w = {16'h0000, usb_vendor_identifier};
    return w;
  endfunction : resp_word

  logic [31:0] word0; // Header word: code, status, length
  assign word0 = {8'h00, len_b, stat_b, new_code};

  //--------------------------------------------------------------------
  // Settings write values
  //--------------------------------------------------------------------
  logic [31:0] cfg_nxt;
  logic [15:0] vid_nxt;
  // Unimplemented bits are dropped so they never read back
  assign cfg_nxt = ((cfg_r & ~lane_m) | (wb_dat_w & lane_m))
                   & fsr_pkg::CFG_MASK;
  assign vid_nxt = (vid_r & ~lane_m[15:0]) |
                   (wb_dat_w[15:0] & lane_m[15:0]);

  //--------------------------------------------------------------------
  // Interrupt edge detection
  //--------------------------------------------------------------------
  logic fall; // Falling edge on synchronised pin
  logic rise; // Rising edge on synchronised pin
  logic int_set;
  logic int_clr;
  logic intr_flag_nxt;

  assign fall = intr_d_r && !intr_s2_r;
  assign rise = !intr_d_r && intr_s2_r;
  assign int_set = (fall && cfg_r[fsr_pkg::INT_NEG_BIT]) ||
                   (rise && cfg_r[fsr_pkg::INT_POS_BIT]);
  assign int_clr = wr_st && wb_dat_w[fsr_pkg::ST_INT_BIT];
  // A new edge outweighs a clear in the same cycle
  assign intr_flag_nxt = int_set || (intr_flag_r && !int_clr);

  //--------------------------------------------------------------------
  // Read mux
  //--------------------------------------------------------------------
  logic [31:0] st_word; // Status: flag and clock-pin routing
  logic [31:0] rd_mux;
  assign st_word = {30'h0000_0000, clkout_assign, intr_flag_r};
  // Unmapped addresses answer with zero data
  assign rd_mux = hit_resp ? resp_mem_r[ridx] :
                  hit_cmd ? {16'h0000, cmd_r} :
                  hit_cfg ? cfg_r :
                  hit_vid ? {16'h0000, vid_r} :
                  hit_st ? st_word : 32'h0000_0000;

  //--------------------------------------------------------------------
  // Bus answer
  //--------------------------------------------------------------------
  // Every access, mapped or not, is acked one cycle after it starts
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r <= acc;
      rdat_r <= acc ? rd_mux : rdat_r;
    end
  end

  //--------------------------------------------------------------------
  // Settings and command registers
  //--------------------------------------------------------------------
  // Stands in for the nonvolatile store, loaded by software
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg_r <= fsr_pkg::CFG_RST;
      vid_r <= fsr_pkg::VID_RST;
      cmd_r <= 16'h0000;
    end
    else
    begin
      cfg_r <= wr_cfg ? cfg_nxt : cfg_r;
      vid_r <= wr_vid ? vid_nxt : vid_r;
      cmd_r <= wr_cmd ? {new_sub, new_code} : cmd_r;
    end
  end

  // Report is rebuilt whole on each command; settings snapshot
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < fsr_pkg::RESP_WORDS; i++)
        resp_mem_r[i] <= 32'h0000_0000;
    end
    else if (wr_cmd)
    begin
      for (int i = 0; i < fsr_pkg::RESP_WORDS; i++)
        resp_mem_r[i] <= resp_word(i, hit_ok, word0, cfg_r, vid_r);
    end
  end

  //--------------------------------------------------------------------
  // Interrupt pin synchroniser and flag
  //--------------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      intr_s1_r <= 1'b0;
      intr_s2_r <= 1'b0;
      intr_d_r <= 1'b0;
      intr_flag_r <= 1'b0;
    end
    else
    begin
      intr_s1_r <= intr_pin;
      intr_s2_r <= intr_s1_r;
      intr_d_r <= intr_s2_r;
      intr_flag_r <= intr_flag_nxt;
    end
  end

  //--------------------------------------------------------------------
  // Clock output divider
  //--------------------------------------------------------------------
  // The core clock stands in for the 48 MHz USB clock here
  fsr_clk_if clk_bus ();
  assign clk_bus.div = cfg_r[fsr_pkg::CLKDIV_LSB +: 5];
  assign clk_bus.en = clkout_assign;

  fsr_clkout u_clkout (
    .mclk (mclk),
    .arst_n (arst_n),
    .clk (clk_bus.gen)
  );

  //--------------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------------
  assign wb_ack = ack_r;
  assign wb_dat_r = rdat_r;
  assign clkout = clk_bus.lvl;
  assign serial_desc_en = cfg_r[fsr_pkg::SN_EN_BIT];
  assign sec_level = cfg_r[fsr_pkg::SEC_LSB +: 2];
  assign dac_vref_sel = cfg_r[fsr_pkg::DAC_REF_LSB +: 2];
  assign dac_src_internal_reference_module =
    cfg_r[fsr_pkg::DAC_SRC_BIT];
  assign dac_code = cfg_r[fsr_pkg::DAC_VAL_LSB +: 5];
  assign adc_vref_sel = cfg_r[fsr_pkg::ADC_REF_LSB +: 2];
  assign ref_src_vdd = cfg_r[fsr_pkg::REF_SRC_BIT];
  assign intr_flag = intr_flag_r;

  //--------------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------------
  sequence s_cmd;
    wr_cmd;
  endsequence

  sequence s_ok_built;
    s_cmd ##1 (resp_mem_r[0][15:8] == fsr_pkg::STAT_OK);
  endsequence

  property p_echo;
    @(posedge mclk) disable iff (!arst_n)
    s_cmd |=> resp_mem_r[0][7:0] == $past(wb_dat_w[7:0]);
  endproperty
  a_echo: assert property (p_echo)
    else $error("response byte 0 does not echo command");

  property p_status;
    @(posedge mclk) disable iff (!arst_n)
    s_cmd |=> resp_mem_r[0][15:8] ==
      ($past(hit_ok) ? fsr_pkg::STAT_OK : fsr_pkg::STAT_UNSUP);
  endproperty
  a_status: assert property (p_status)
    else $error("response status byte wrong");

  property p_len;
    @(posedge mclk) disable iff (!arst_n)
    s_ok_built |-> resp_mem_r[0][23:16] == STRUCT_LEN &&
                   resp_mem_r[1] == ($past(cfg_r) & fsr_pkg::CFG_MASK);
  endproperty
  a_len: assert property (p_len)
    else $error("length or settings bytes wrong on success");

  property p_unsup;
    @(posedge mclk) disable iff (!arst_n)
    (s_cmd ##0 !hit_ok) |=> resp_mem_r[1] == 32'h0000_0000 &&
      resp_mem_r[0][31:16] == 16'h0000;
  endproperty
  a_unsup: assert property (p_unsup)
    else $error("unsupported reply carries data");

  property p_tail;
    @(posedge mclk) disable iff (!arst_n)
    s_cmd |=> resp_mem_r[3] == 32'h0000_0000 &&
      resp_mem_r[fsr_pkg::RESP_WORDS-1] == 32'h0000_0000;
  endproperty
  a_tail: assert property (p_tail)
    else $error("unused response bytes not zero");

  property p_vid;
    @(posedge mclk) disable iff (!arst_n)
    s_ok_built |-> resp_mem_r[2] == {16'h0000, $past(vid_r)};
  endproperty
  a_vid: assert property (p_vid)
    else $error("vendor identifier bytes wrong");

  property p_rsvd;
    @(posedge mclk) disable iff (!arst_n)
    (cfg_r & ~fsr_pkg::CFG_MASK) == 32'h0000_0000;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("unimplemented settings bit stored");

  property p_neg;
    @(posedge mclk) disable iff (!arst_n)
    ($fell(intr_s2_r) && cfg_r[fsr_pkg::INT_NEG_BIT]) |=> intr_flag_r;
  endproperty
  a_neg: assert property (p_neg)
    else $error("falling edge did not set flag");

  property p_pos;
    @(posedge mclk) disable iff (!arst_n)
    ($rose(intr_s2_r) && cfg_r[fsr_pkg::INT_POS_BIT]) |=> intr_flag_r;
  endproperty
  a_pos: assert property (p_pos)
    else $error("rising edge did not set flag");

  property p_ack;
    @(posedge mclk) disable iff (!arst_n)
    acc |=> wb_ack ##1 !wb_ack;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus ack not a single cycle after request");

endmodule : fsr_flash_resp

// File: testbench/fsr_host_model.sv
`timescale 1ns/1ps
//--------------------------------------------------
// Host software model: issues classic bus cycles
//--------------------------------------------------
module fsr_host_model (
  // Clock
  input wire logic mclk,
  // Bus towards the block
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [3:0] sel,
  output logic [31:0] wdat,
  input wire logic [31:0] rdat,
  input wire logic ack
);
  // Idle bus from time zero
  initial
  begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0000_0000;
  end

  // One cycle; held until ack is seen at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [3:0] s, output logic [31:0] q);
    int n;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    // A lost answer leaves unknown data so the compare fails
    q = (n < 50) ? rdat : 32'hxxxx_xxxx;
    cyc <= 1'b0;
    stb <= 1'b0;
    // Released address and data lines carry a changed value, not the last one
    wdat <= ~d;
    adr <= ~a;
  endtask : xfer
endmodule : fsr_host_model

// File: testbench/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    compares++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("BAD %0t got %h exp %h", $time, (g), (e)); \
    end \
  end
//--------------------------------------------------
// Response builder bench
//--------------------------------------------------
module tb_top;
  // Bench clock, reset and pins
  logic mclk, arst_n, intr_pin, clkout_assign;
  // Bus wires between host model and block
  logic wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r, q;
  // Settings outputs
  logic clkout, serial_desc_en, dac_src, ref_src_vdd, intr_flag;
  logic [1:0] sec_level, dac_vref_sel, adc_vref_sel;
  logic [4:0] dac_code;
  int n_errors = 0;
  int compares = 0;
  // Code and sub-code pairs that must be refused
  localparam logic [15:0] BADC [7] = '{16'h01B0, 16'h02B0,
    16'h03B0, 16'h04B0, 16'h05B0, 16'hFFB0, 16'h0055};
  localparam int DIVS [4] = '{0, 1, 4, 31};

  fsr_host_model host (.mclk(mclk), .cyc(wb_cyc), .stb(wb_stb),
    .we(wb_we), .adr(wb_adr), .sel(wb_sel), .wdat(wb_dat_w),
    .rdat(wb_dat_r), .ack(wb_ack));

  fsr_flash_resp #(.STRUCT_LEN(8'h0A)) dut (.mclk(mclk),
    .arst_n(arst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .intr_pin(intr_pin),
    .clkout_assign(clkout_assign), .clkout(clkout),
    .serial_desc_en(serial_desc_en), .sec_level(sec_level),
    .dac_vref_sel(dac_vref_sel),
    .dac_src_internal_reference_module(dac_src),
    .dac_code(dac_code), .adc_vref_sel(adc_vref_sel),
    .ref_src_vdd(ref_src_vdd), .intr_flag(intr_flag));

  //--------------------------------------------------
  // Bus helpers
  //--------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    logic [31:0] u;
    host.xfer(1'b1, a, d, s, u);
    // A write that is never answered comes back unknown
    `CHK($isunknown(u), 1'b0)
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    host.xfer(1'b0, a, 32'h0000_0000, 4'hF, d);
  endtask : rd

  //--------------------------------------------------
  // Scenarios
  //--------------------------------------------------
  // Power-up contents, and a place with nothing behind it
  task automatic t_reset;
    rd(fsr_pkg::ADR_CFG, q);
    `CHK(q, 32'h0000_0000)
    wr(8'h20, 32'hFFFF_FFFF, 4'hF);
    rd(8'h20, q);
    `CHK(q, 32'h0000_0000)
    rd(8'h40, q);
    `CHK(q, 32'h0000_0000)
    `CHK(serial_desc_en, 1'b0)
  endtask : t_reset

  // Full chip-settings report, word by word
  task automatic t_chip;
    logic [31:0] e;
    wr(fsr_pkg::ADR_CFG, 32'hFFFF_FFFF, 4'hF);
    rd(fsr_pkg::ADR_CFG, q);
    `CHK(q, 32'h7CFF_1F83)
    wr(fsr_pkg::ADR_CFG, 32'h54B7_1581, 4'hF);
    wr(fsr_pkg::ADR_VID, 32'hFFFF_A5C3, 4'h3);
    rd(fsr_pkg::ADR_VID, q);
    `CHK(q, 32'h0000_A5C3)
    wr(fsr_pkg::ADR_CMD, 32'h0000_00B0, 4'h3);
    for (int i = 0; i < 16; i++)
    begin
      rd(8'h40 + 8'(4 * i), q);
      e = (i == 0) ? 32'h000A_00B0 : (i == 1) ? 32'h54B7_1581 :
        (i == 2) ? 32'h0000_A5C3 : 32'h0000_0000;
      `CHK(q, e)
    end
    `CHK(serial_desc_en, 1'b1)
    `CHK(sec_level, 2'b01)
    `CHK(dac_vref_sel, 2'b10)
    `CHK(dac_src, 1'b1)
    `CHK(dac_code, 5'h17)
    `CHK(adc_vref_sel, 2'b10)
    `CHK(ref_src_vdd, 1'b1)
  endtask : t_chip

  // Refused sub-codes 01 to 05 and FF, and a foreign command code
  task automatic t_unsup;
    for (int i = 0; i < 7; i++)
    begin
      wr(fsr_pkg::ADR_CMD, {16'h0000, BADC[i]}, 4'h3);
      rd(8'h40, q);
      `CHK(q, {16'h0000, 8'h01, BADC[i][7:0]})
      rd(8'h44, q);
      `CHK(q, 32'h0000_0000)
    end
    // Sub-code lane not enabled: reads as chip settings
    wr(fsr_pkg::ADR_CMD, 32'h0000_07B0, 4'h1);
    rd(8'h40, q);
    `CHK(q, 32'h000A_00B0)
    rd(fsr_pkg::ADR_CMD, q);
    `CHK(q, 32'h0000_00B0)
  endtask : t_unsup

  // Drive the pin and let the synchroniser settle
  task automatic pin(input logic v);
    @(posedge mclk);
    intr_pin <= v;
    repeat (8) @(posedge mclk);
  endtask : pin

  // Edge detection armed for one edge at a time
  task automatic t_intr;
    wr(fsr_pkg::ADR_CFG, 32'h4000_0000, 4'hF);
    `CHK(serial_desc_en, 1'b0)
    pin(1'b1);
    `CHK(intr_flag, 1'b0)
    pin(1'b0);
    `CHK(intr_flag, 1'b1)
    rd(fsr_pkg::ADR_STATUS, q);
    `CHK(q, 32'h0000_0001)
    wr(fsr_pkg::ADR_STATUS, 32'h0000_0001, 4'h1);
    wr(fsr_pkg::ADR_CFG, 32'h2000_0000, 4'hF);
    pin(1'b1);
    `CHK(intr_flag, 1'b1)
    wr(fsr_pkg::ADR_STATUS, 32'h0000_0001, 4'h1);
    pin(1'b0);
    `CHK(intr_flag, 1'b0)
  endtask : t_intr

  // High phase of the divided clock for several dividers
  task automatic t_clk;
    int n, h;
    wr(fsr_pkg::ADR_CFG, 32'h0000_0300, 4'hF);
    repeat (10) @(posedge mclk);
    `CHK(clkout, 1'b0)
    clkout_assign <= 1'b1;
    // A zero divider runs as one
    for (int i = 0; i < 4; i++)
    begin
      wr(fsr_pkg::ADR_CFG, 32'(DIVS[i]) << 8, 4'h2);
      n = 0;
      while (clkout !== 1'b0 && n < 99)
      begin
        @(posedge mclk);
        n++;
      end
      while (clkout !== 1'b1 && n < 99)
      begin
        @(posedge mclk);
        n++;
      end
      h = 0;
      while (clkout === 1'b1 && h < 99)
      begin
        @(posedge mclk);
        h++;
      end
      `CHK(h, (DIVS[i] == 0) ? 1 : DIVS[i])
    end
    rd(fsr_pkg::ADR_STATUS, q);
    `CHK(q, 32'h0000_0002)
  endtask : t_clk

  //--------------------------------------------------
  // Closing, clock, watchdog and main sequence
  //--------------------------------------------------
  task automatic final_report;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report

  // 100 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Well beyond the few hundred cycles the scenarios need
  initial
  begin
    #200000;
    $display("BAD %0t watchdog expired", $time);
    n_errors++;
    final_report();
  end

  initial
  begin
    arst_n = 1'b0;
    intr_pin = 1'b0;
    clkout_assign = 1'b0;
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    t_reset();
    t_chip();
    t_unsup();
    t_intr();
    t_clk();
    final_report();
  end
endmodule : tb_top
